// ===== hw/timer_pair_map.svh
// Register offsets, field positions and reset values of the timer pair.
`ifndef TIMER_PAIR_MAP_SVH
`define TIMER_PAIR_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_PAIR_MODE     8'h00
`define OFS_FF_CTRL       8'h04
`define OFS_LOWER_CMP     8'h08
`define OFS_UPPER_CMP     8'h0c
`define OFS_RUN_CTRL      8'h10
`define OFS_STATUS        8'h14

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define POS_LOWER_CLK     0
`define POS_UPPER_CLK     2
`define POS_PWM_PERIOD    4
`define POS_PAIR_MODE     6
`define POS_TOGGLE_SRC    0
`define POS_TOGGLE_EN     1
`define POS_FF_INIT       2
`define POS_DBL_BUF       7
`define POS_LOWER_RUN     0
`define POS_UPPER_RUN     1
`define POS_PRESC_RUN     7
`define POS_STAT_UPPER    8
`define POS_STAT_FF       16

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_PAIR_MODE     8'h00
`define RST_FF_CTRL       8'h00
`define RST_RUN_CTRL      8'h00
`define RST_COMPARE       8'h00

// ----------------------------------------------------------------------
// Counter limits for the selectable PWM periods
// ----------------------------------------------------------------------
`define PWM_TOP_N6        8'h3f
`define PWM_TOP_N7        8'h7f
`define PWM_TOP_N8        8'hff

`endif

// ===== hw/timer_pair_pkg.sv
// Types shared by the timer pair design.
package timer_pair_pkg;

    typedef enum logic [1:0] {
        MODE_DUAL    = 2'b00,
        MODE_CASCADE = 2'b01,
        MODE_PULSE   = 2'b10,
        MODE_PWM     = 2'b11
    } pair_mode_t;

    typedef enum logic [1:0] {
        FF_CMD_NONE  = 2'b00,
        FF_CMD_SET   = 2'b01,
        FF_CMD_CLEAR = 2'b10,
        FF_CMD_KEEP  = 2'b11
    } ff_cmd_t;

endpackage : timer_pair_pkg

// ===== hw/timer_pair.sv
// Pair of 8-bit up-counters with shared output toggle flip-flop and four pair modes.
//
// How it works
// - Init command 10 clears, 01 sets flip-flop.
// - Compare registers are write-only, read zero.
// - Pair mode 01 cascades into 16-bit timer.
// - Cascade: upper counts lower overflow, ignores select.
// - Cascade lower compare write holds comparison until upper.
// - Cascade lower match: signal only, no clear.
// - Cascade full match clears both, upper irq.
// - Pulse mode toggles on either compare match.
// - Pulse mode reloads buffer on period match.
// - PWM on lower only; upper stays usable.
// - PWM toggles on match or 2^n-1 overflow.
// - PWM clears lower counter on 2^n-1 overflow.
// - Pair mode 00: two independent 8-bit timers.
// - Lower clock: external, div8, div32, div128.
// - Upper clock: lower match (dual mode only), div8, div128, div2048.
// - Toggle source bit picks lower or upper match (dual mode only).
// - Pulse waveform drives the wave output pin.
// - PWM mode: upper uses taps, no toggling.
// - Interval match clears counter, raises irq.
// - Double buffer bit enables buffering, resets 0.
// - Lower compare write always updates buffer; compare directly only when disabled.
`timescale 1ns/1ps

`include "timer_pair_map.svh"

module timer_pair
    import timer_pair_pkg::*;
#(
    parameter int PRESC_W = 11
) (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        ext_count_in,
    output logic             wave_out_pin,
    output logic             lower_match_irq,
    output logic             upper_match_irq
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // The slowest tap divides by 2048, so the prescaler needs 11 bits.
    if (PRESC_W < 11) begin : g_presc_check
        $error("PRESC_W must be at least 11");
    end

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0]         pair_mode_reg_q;
    logic [7:0]         flipflop_control_reg_q;
    logic [7:0]         run_control_reg_q;
    logic [7:0]         lower_compare_reg_q;
    logic [7:0]         lower_buf_q;
    logic [7:0]         upper_compare_reg_q;
    logic               cmp_hold_q;
    logic [7:0]         lower_counter_q;
    logic [7:0]         upper_counter_q;
    logic               output_toggle_ff_q;
    logic               lower_irq_q;
    logic               upper_irq_q;
    logic [PRESC_W-1:0] presc_q;
    logic               ext_meta_q;
    logic               ext_sync_q;
    logic               ext_prev_q;
    logic               ack_q;
    logic [31:0]        readdata_q;

    pair_mode_t         pair_mode_field;
    logic [1:0]         lower_clk_sel;
    logic [1:0]         upper_clk_sel;
    logic [1:0]         pwm_period_sel;
    logic               ff_toggle_src_sel;
    logic               toggle_en;
    logic               dbl_buf_enable;
    logic               lower_run;
    logic               upper_run_bit;
    logic               presc_run;
    ff_cmd_t            ff_init_cmd;

    logic               wr_go;
    logic               ext_edge;
    logic               presc_tap_div8;
    logic               presc_tap_div32;
    logic               presc_tap_div128;
    logic               presc_tap_div2048;
    logic               lo_tick;
    logic               hi_src;
    logic               hi_tick;
    logic [7:0]         lo_inc;
    logic [7:0]         hi_inc;
    logic [7:0]         hi_nxt;
    logic [7:0]         pwm_top;
    logic               lo_match;
    logic               hi_match;
    logic               lo_ovf;
    logic [7:0]         lower_counter_d;
    logic [7:0]         upper_counter_d;
    logic               toggle_ev;
    logic               lo_irq_ev;
    logic               hi_irq_ev;
    logic               load_buf;

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    assign pair_mode_field   = pair_mode_t'(pair_mode_reg_q[`POS_PAIR_MODE +: 2]);
    assign lower_clk_sel     = pair_mode_reg_q[`POS_LOWER_CLK +: 2];
    assign upper_clk_sel     = pair_mode_reg_q[`POS_UPPER_CLK +: 2];
    assign pwm_period_sel    = pair_mode_reg_q[`POS_PWM_PERIOD +: 2];
    assign ff_toggle_src_sel = flipflop_control_reg_q[`POS_TOGGLE_SRC];
    assign toggle_en         = flipflop_control_reg_q[`POS_TOGGLE_EN];
    assign dbl_buf_enable    = flipflop_control_reg_q[`POS_DBL_BUF];
    assign lower_run         = run_control_reg_q[`POS_LOWER_RUN];
    assign upper_run_bit     = run_control_reg_q[`POS_UPPER_RUN];
    assign presc_run         = run_control_reg_q[`POS_PRESC_RUN];
    assign ff_init_cmd       = ff_cmd_t'(writedata[`POS_FF_INIT +: 2]);

    // ------------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------------
    // Every access waits exactly one cycle; read data is captured on the
    // first edge so it is stable at the edge where waitrequest is low.
    assign waitrequest = (read | write) & ~ack_q;
    assign wr_go       = write & ack_q & byteenable[0];
    assign readdata    = readdata_q;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (read | write) & ~ack_q;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            readdata_q <= 32'h0000_0000;
        end else if (read && !ack_q) begin
            readdata_q <= 32'h0000_0000;
            unique case (address)
                `OFS_PAIR_MODE: readdata_q[7:0] <= pair_mode_reg_q;
                `OFS_FF_CTRL:   readdata_q[7:0] <= flipflop_control_reg_q & ~(8'h03 << `POS_FF_INIT);
                `OFS_RUN_CTRL:  readdata_q[7:0] <= run_control_reg_q;
                `OFS_STATUS: begin
                    readdata_q[7:0]                      <= lower_counter_q;
                    readdata_q[`POS_STAT_UPPER +: 8]     <= upper_counter_q;
                    readdata_q[`POS_STAT_FF]             <= output_toggle_ff_q;
                end
                // compare reads hidden
                // Compare offsets and unmapped addresses read as zero.
                default:        readdata_q <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pair_mode_reg_q        <= `RST_PAIR_MODE;
            flipflop_control_reg_q <= `RST_FF_CTRL;
            run_control_reg_q      <= `RST_RUN_CTRL;
        end else if (wr_go) begin
            if (address == `OFS_PAIR_MODE) begin
                pair_mode_reg_q <= writedata[7:0];
            end
            if (address == `OFS_FF_CTRL) begin
                flipflop_control_reg_q <= writedata[7:0];
            end
            if (address == `OFS_RUN_CTRL) begin
                run_control_reg_q <= writedata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Compare registers and lower buffer
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lower_buf_q         <= `RST_COMPARE;
            lower_compare_reg_q <= `RST_COMPARE;
        end else begin
            if (wr_go && address == `OFS_LOWER_CMP) begin
                lower_buf_q <= writedata[7:0];
            end
            if (wr_go && address == `OFS_LOWER_CMP && !dbl_buf_enable) begin
                lower_compare_reg_q <= writedata[7:0];
            end else if (load_buf) begin
                lower_compare_reg_q <= lower_buf_q;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            upper_compare_reg_q <= `RST_COMPARE;
        end else if (wr_go && address == `OFS_UPPER_CMP) begin
            upper_compare_reg_q <= writedata[7:0];
        end
    end

    // suspend until upper write
    // The upper write releases the hold even when it lands after a mode change.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cmp_hold_q <= 1'b0;
        end else if (wr_go && address == `OFS_UPPER_CMP) begin
            cmp_hold_q <= 1'b0;
        end else if (wr_go && address == `OFS_LOWER_CMP && pair_mode_field == MODE_CASCADE) begin
            cmp_hold_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Prescaler and external count input
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            presc_q <= '0;
        end else if (!presc_run) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + 1'b1;
        end
    end

    assign presc_tap_div8    = presc_run & (&presc_q[2:0]);
    assign presc_tap_div32   = presc_run & (&presc_q[4:0]);
    assign presc_tap_div128  = presc_run & (&presc_q[6:0]);
    assign presc_tap_div2048 = presc_run & (&presc_q[10:0]);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end else begin
            ext_meta_q <= ext_count_in;
            ext_sync_q <= ext_meta_q;
            ext_prev_q <= ext_sync_q;
        end
    end

    // Counting on the rising edge only; the pin must stay high and low for
    // at least two clock periods each to be seen.
    assign ext_edge = ext_sync_q & ~ext_prev_q;

    // ------------------------------------------------------------------
    // Count and match logic
    // ------------------------------------------------------------------
    always_comb begin
        lo_inc = lower_counter_q + 8'h01;
        hi_inc = upper_counter_q + 8'h01;

        unique case (lower_clk_sel)
            2'b00:   lo_tick = ext_edge;
            2'b01:   lo_tick = presc_tap_div8;
            2'b10:   lo_tick = presc_tap_div32;
            default: lo_tick = presc_tap_div128;
        endcase
        lo_tick = lo_tick & lower_run;

        lo_ovf   = lo_tick & (lower_counter_q == 8'hff);
        lo_match = lo_tick & (lo_inc == lower_compare_reg_q) & ~cmp_hold_q;

        if (pair_mode_field == MODE_CASCADE) begin
            hi_src = lo_ovf;
        end else begin
            unique case (upper_clk_sel)
                2'b00:   hi_src = (pair_mode_field == MODE_DUAL) & lo_match;
                2'b01:   hi_src = presc_tap_div8;
                2'b10:   hi_src = presc_tap_div128;
                default: hi_src = presc_tap_div2048;
            endcase
        end
        hi_tick  = hi_src & upper_run_bit;
        hi_nxt   = hi_tick ? hi_inc : upper_counter_q;
        hi_match = hi_tick & (hi_inc == upper_compare_reg_q) & ~cmp_hold_q;

        unique case (pwm_period_sel)
            2'b01:   pwm_top = `PWM_TOP_N6;
            2'b10:   pwm_top = `PWM_TOP_N7;
            default: pwm_top = `PWM_TOP_N8;
        endcase

        lower_counter_d = lo_tick ? lo_inc : lower_counter_q;
        upper_counter_d = hi_nxt;
        toggle_ev       = 1'b0;
        lo_irq_ev       = 1'b0;
        hi_irq_ev       = 1'b0;
        load_buf        = 1'b0;

        unique case (pair_mode_field)
            MODE_DUAL: begin
                if (lo_match) begin
                    lower_counter_d = 8'h00;
                    lo_irq_ev       = 1'b1;
                end
                if (hi_match) begin
                    upper_counter_d = 8'h00;
                    hi_irq_ev       = 1'b1;
                end
                toggle_ev = ff_toggle_src_sel ? hi_match : lo_match;
            end
            MODE_CASCADE: begin
                if (lo_match && hi_nxt == upper_compare_reg_q) begin
                    lower_counter_d = 8'h00;
                    upper_counter_d = 8'h00;
                    hi_irq_ev       = 1'b1;
                    toggle_ev       = 1'b1;
                end
            end
            MODE_PULSE: begin
                // period restart at upper compare
                // The upper counter free-runs here and never matches.
                if (lo_tick && lo_inc == upper_compare_reg_q) begin
                    lower_counter_d = 8'h00;
                    lo_irq_ev       = 1'b1;
                    toggle_ev       = 1'b1;
                    load_buf        = dbl_buf_enable;
                end else if (lo_tick && lo_inc == lower_compare_reg_q) begin
                    toggle_ev = 1'b1;
                end
            end
            default: begin
                // overflow clears lower counter
                // The overflow outranks the match so 0 and 100 percent duty work.
                if (lo_tick && lower_counter_q == pwm_top) begin
                    lower_counter_d = 8'h00;
                    lo_irq_ev       = 1'b1;
                    toggle_ev       = 1'b1;
                    load_buf        = dbl_buf_enable;
                end else if (lo_tick && lo_inc == lower_compare_reg_q) begin
                    toggle_ev = 1'b1;
                end
                if (hi_match) begin
                    upper_counter_d = 8'h00;
                    hi_irq_ev       = 1'b1;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------------
    // stopped counters hold zero
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lower_counter_q <= 8'h00;
        end else if (!lower_run) begin
            lower_counter_q <= 8'h00;
        end else begin
            lower_counter_q <= lower_counter_d;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            upper_counter_q <= 8'h00;
        end else if (!upper_run_bit) begin
            upper_counter_q <= 8'h00;
        end else begin
            upper_counter_q <= upper_counter_d;
        end
    end

    // ------------------------------------------------------------------
    // Output flip-flop and match pulses
    // ------------------------------------------------------------------
    // A software force in the same cycle as a toggle wins, so the written
    // level is what software reads back.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            output_toggle_ff_q <= 1'b0;
        end else if (wr_go && address == `OFS_FF_CTRL && ff_init_cmd == FF_CMD_CLEAR) begin
            output_toggle_ff_q <= 1'b0;
        end else if (wr_go && address == `OFS_FF_CTRL && ff_init_cmd == FF_CMD_SET) begin
            output_toggle_ff_q <= 1'b1;
        end else if (toggle_ev && toggle_en) begin
            output_toggle_ff_q <= ~output_toggle_ff_q;
        end
    end

    assign wave_out_pin = output_toggle_ff_q;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lower_irq_q <= 1'b0;
            upper_irq_q <= 1'b0;
        end else begin
            lower_irq_q <= lo_irq_ev;
            upper_irq_q <= hi_irq_ev;
        end
    end

    assign lower_match_irq = lower_irq_q;
    assign upper_match_irq = upper_irq_q;

endmodule : timer_pair

// ===== verif/timer_pair_chk.sv
// Port checker for the timer pair.
`timescale 1ns/1ps
`include "timer_pair_map.svh"
module timer_pair_chk
    import timer_pair_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        wave_out_pin,
    input wire logic        lower_match_irq,
    input wire logic        upper_match_irq
);
    // ------------------------------------------------------------------
    // Shadow of the configuration seen on the bus
    // ------------------------------------------------------------------
    logic       wr_done;
    logic       ff_wr;
    pair_mode_t mode_q;
    logic [1:0] run_q;
    logic       ten_q;
    assign wr_done = write && !waitrequest && byteenable[0];
    assign ff_wr   = wr_done && address == `OFS_FF_CTRL;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= MODE_DUAL;
            run_q  <= 2'h0;
            ten_q  <= 1'b0;
        end else if (wr_done) begin
            if (address == `OFS_PAIR_MODE) mode_q <= pair_mode_t'(writedata[7:6]);
            if (address == `OFS_RUN_CTRL) run_q <= writedata[1:0];
            if (ff_wr) ten_q <= writedata[`POS_TOGGLE_EN];
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    chk_ff_clear: assert property (ff_wr && writedata[3:2] == 2'b10 |=> !wave_out_pin)
        else $error("flip-flop not cleared");
    chk_ff_set: assert property (ff_wr && writedata[3:2] == 2'b01 |=> wave_out_pin)
        else $error("flip-flop not set");
    chk_cmp_unread: assert property (read && !waitrequest && address[7:3] == 5'h01 |-> readdata == 32'h0)
        else $error("compare value readable");
    chk_cascade_lower: assert property ((mode_q == MODE_CASCADE)[*3] |-> !lower_match_irq)
        else $error("lower interrupt in cascade");
    chk_pulse_upper: assert property ((mode_q == MODE_PULSE)[*3] |-> !upper_match_irq)
        else $error("upper interrupt in pulse mode");
    chk_stop_lower: assert property (!run_q[0] && !$past(run_q[0]) && !$past(run_q[0], 2) |-> !lower_match_irq)
        else $error("stopped lower counter interrupts");
    chk_stop_upper: assert property (!run_q[1] && !$past(run_q[1]) && !$past(run_q[1], 2) |-> !upper_match_irq)
        else $error("stopped upper counter interrupts");
    chk_toggle_gate: assert property ($changed(wave_out_pin) |-> $past(ten_q) || $past(ff_wr))
        else $error("output toggled while disabled");
    chk_irq_pulse: assert property (lower_match_irq |=> !lower_match_irq)
        else $error("lower interrupt longer than one cycle");
endmodule : timer_pair_chk

// ===== verif/timer_pair_tb.sv
// Self-checking testbench for the timer pair.
`timescale 1ns/1ps
`include "timer_pair_map.svh"
module timer_pair_tb;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  address = 8'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0]  byteenable = 4'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        ext_count_in = 1'b0;
    logic        wave_out_pin;
    logic        lower_match_irq;
    logic        upper_match_irq;
    int          error_cnt = 0;
    int          num_checks = 0;
    int          cyc = 0;
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    // External events arrive slower than the synchroniser needs: one rise per ten cycles.
    always begin
        repeat (5) @(posedge sys_clk);
        ext_count_in <= ~ext_count_in;
    end
    timer_pair #(.PRESC_W(11)) i_timer_pair (.sys_clk(sys_clk), .rstn(rstn), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .ext_count_in(ext_count_in), .wave_out_pin(wave_out_pin),
        .lower_match_irq(lower_match_irq), .upper_match_irq(upper_match_irq));
    // ------------------------------------------------------------------
    // Bus and measurement helpers
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    task automatic bus(input logic [7:0] a, input logic is_wr, input logic [7:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        address <= a;
        write <= is_wr;
        read <= !is_wr;
        writedata <= {24'h0, d};
        byteenable <= 4'hf;
        do @(posedge sys_clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask : wr
    task automatic wait_irq(input logic up);
        do @(posedge sys_clk); while ((up ? upper_match_irq : lower_match_irq) !== 1'b1);
    endtask : wait_irq
    task automatic gap(input logic up, input logic [31:0] exp, input string what);
        int t0;
        wait_irq(up);
        t0 = cyc;
        wait_irq(up);
        check(what, exp, cyc - t0);
    endtask : gap
    // Cycles from a period-end interrupt to the next output change.
    task automatic wave_delay(input logic do_wr, output int n);
        int   t0;
        logic w;
        wait_irq(1'b0);
        t0 = cyc;
        if (do_wr) wr(`OFS_LOWER_CMP, 8'h04);
        else repeat (2) @(posedge sys_clk);
        w = wave_out_pin;
        do @(posedge sys_clk); while (wave_out_pin === w);
        n = cyc - t0;
    endtask : wave_delay
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        logic [31:0] q;
        wr(`OFS_FF_CTRL, 8'h04);
        @(posedge sys_clk);
        check("wave after set", 1, wave_out_pin);
        wr(`OFS_FF_CTRL, 8'h08);
        @(posedge sys_clk);
        check("wave after clear", 0, wave_out_pin);
        wr(`OFS_LOWER_CMP, 8'h55);
        wr(`OFS_UPPER_CMP, 8'haa);
        bus(`OFS_LOWER_CMP, 1'b0, 8'h0, q);
        check("lower compare read", 0, q);
        bus(`OFS_UPPER_CMP, 1'b0, 8'h0, q);
        check("upper compare read", 0, q);
        bus(8'h20, 1'b0, 8'h0, q);
        check("unmapped read", 0, q);
        bus(`OFS_STATUS, 1'b0, 8'h0, q);
        check("stopped counters", 0, q);
    endtask : t_regs
    task automatic t_dual();
        int per[4] = '{10, 8, 32, 128};
        logic w;
        wr(`OFS_FF_CTRL, 8'h02);
        wr(`OFS_UPPER_CMP, 8'h02);
        for (int s = 0; s < 4; s++) begin
            wr(`OFS_RUN_CTRL, 8'h00);
            wr(`OFS_PAIR_MODE, 8'(s));
            wr(`OFS_LOWER_CMP, 8'h02);
            wr(`OFS_RUN_CTRL, 8'h83);
            gap(1'b0, 2 * per[s], "lower interval");
        end
        gap(1'b1, 512, "upper on lower match");
        // Upper matches every second lower match, so only every other one may toggle.
        wr(`OFS_FF_CTRL, 8'h03);
        wait_irq(1'b1);
        w = wave_out_pin;
        wait_irq(1'b0);
        check("wave on lower match", w, wave_out_pin);
        wait_irq(1'b1);
        check("wave on upper match", !w, wave_out_pin);
    endtask : t_dual
    task automatic t_cascade();
        logic seen = 1'b0;
        wr(`OFS_RUN_CTRL, 8'h00);
        wr(`OFS_PAIR_MODE, 8'h4d);
        wr(`OFS_UPPER_CMP, 8'h01);
        wr(`OFS_LOWER_CMP, 8'h02);
        wr(`OFS_RUN_CTRL, 8'h83);
        repeat (2500) begin
            @(posedge sys_clk);
            seen = seen | upper_match_irq;
        end
        check("suspended compare", 0, seen);
        wr(`OFS_UPPER_CMP, 8'h01);
        wr(`OFS_RUN_CTRL, 8'h00);
        wr(`OFS_RUN_CTRL, 8'h83);
        gap(1'b1, 258 * 8, "cascade interval");
    endtask : t_cascade
    task automatic t_pulse();
        int d0;
        int d1;
        int d2;
        wr(`OFS_RUN_CTRL, 8'h00);
        wr(`OFS_PAIR_MODE, 8'h81);
        wr(`OFS_FF_CTRL, 8'h02);
        wr(`OFS_LOWER_CMP, 8'h02);
        wr(`OFS_UPPER_CMP, 8'h06);
        wr(`OFS_RUN_CTRL, 8'h83);
        gap(1'b0, 48, "pulse period");
        wave_delay(1'b0, d0);
        check("pulse lower toggle", 16, d0);
        wr(`OFS_FF_CTRL, 8'h82);
        wave_delay(1'b1, d1);
        check("buffered write", d0, d1);
        wave_delay(1'b0, d2);
        check("reloaded compare", d0 + 16, d2);
    endtask : t_pulse
    task automatic t_pwm();
        int d;
        wr(`OFS_FF_CTRL, 8'h02);
        for (int s = 1; s < 4; s++) begin
            wr(`OFS_RUN_CTRL, 8'h00);
            wr(`OFS_PAIR_MODE, 8'hc5 | 8'(s << 4));
            wr(`OFS_LOWER_CMP, 8'h10);
            wr(`OFS_UPPER_CMP, 8'h03);
            wr(`OFS_RUN_CTRL, 8'h83);
            gap(1'b0, 8 << (5 + s), "pwm period");
            gap(1'b1, 24, "upper beside pwm");
            wave_delay(1'b0, d);
            check("pwm match toggle", 128, d);
        end
    endtask : t_pwm
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        t_regs();
        t_dual();
        t_cascade();
        t_pulse();
        t_pwm();
        end_of_test();
    end
    initial begin
        repeat (60000) @(posedge sys_clk);
        error_cnt++;
        end_of_test();
    end
endmodule : timer_pair_tb
bind timer_pair timer_pair_chk i_timer_pair_chk (.sys_clk(sys_clk), .rstn(rstn), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .wave_out_pin(wave_out_pin), .lower_match_irq(lower_match_irq),
    .upper_match_irq(upper_match_irq));
